// file: rtl/ctc_consts.svh
// Constants for the per-channel test control register block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef CTC_CONSTS_SVH
`define CTC_CONSTS_SVH

// ----------------------------------------
// Register address and reset
// ----------------------------------------
`define CTC_ADDR_TEST_CTRL 7'h17
`define CTC_RESET_TEST_CTRL 16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTC_BIT_SHUTOFF_ON_SCLK 15
`define CTC_BIT_SDATA_DELAY 14
`define CTC_BIT_STROBE_DELAY 13
`define CTC_BIT_COEF_FLOAT 12
`define CTC_BIT_PAD_HOLD_LO 8
`define CTC_BIT_PAD_HOLD_HI 10
`define CTC_BIT_PN_ENABLE 7
`define CTC_BIT_PN_FAST 6
`define CTC_BIT_STRAIGHT_THRU 4
`define CTC_BIT_PN_SELECT 3
`define CTC_BIT_FORCE_EDGE 2
`define CTC_BIT_FORCE_POP 1
`define CTC_BIT_FORCE_CARRIER 0

// ----------------------------------------
// Write masks
// ----------------------------------------
`define CTC_MASK_ALL_CHANNELS 16'hF7DF
`define CTC_MASK_CH0_ONLY 16'h0780

// ----------------------------------------
// Forced carrier value and noise source
// ----------------------------------------
`define CTC_CARRIER_FORCE 18'h1FFFF
`define CTC_PN_SEED 16'hACE1
`define CTC_PN_TAPS 16'hB400

`endif

// file: rtl/ctc_pkg.sv
// Types shared by the channel test control block.
// Assumes the constants header sits beside it in rtl/.
package ctc_pkg;

	// ----------------------------------------
	// Carried groups
	// ----------------------------------------
	// Carrier sine and cosine pair
	typedef struct packed {
		logic [17:0] sin_val;
		logic [17:0] cos_val;
	} ctc_carrier_t;

	// One FIFO input word with its valid flag
	typedef struct packed {
		logic [15:0] data;
		logic valid;
	} ctc_sample_t;

endpackage

// file: rtl/ctc_pn_source.sv
// Pseudo-noise source: Galois LFSR stepped by an advance pulse.
// Assumes a synchronous active-high reset and a single clock.
`timescale 1ns/1ps
`default_nettype none
`include "ctc_consts.svh"

module ctc_pn_source
	import ctc_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Control
	input wire logic advance_i,
	// Noise word
	output logic [WIDTH-1:0] pn_data_o
);

	// ----------------------------------------
	// Shift register
	// ----------------------------------------
	logic [WIDTH-1:0] lfsr_reg; // Current noise state
	logic [WIDTH-1:0] lfsr_next; // Next noise state

	// Step only on advance; a zero state would lock up, seed avoids it
	always_comb
	begin
		lfsr_next = lfsr_reg;
		if (advance_i)
		begin
			if (lfsr_reg[0])
				lfsr_next = (lfsr_reg >> 1) ^ WIDTH'(`CTC_PN_TAPS);
			else
				lfsr_next = lfsr_reg >> 1;
		end
	end

	// Register the state
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			lfsr_reg <= WIDTH'(`CTC_PN_SEED);
		else
			lfsr_reg <= lfsr_next;
	end

	assign pn_data_o = lfsr_reg;

endmodule // ctc_pn_source
`default_nettype wire

// file: rtl/ctc_channel_test_control.sv
// Per-channel test control register and the test/bypass steering it drives.
// Assumes host port inputs synchronous to mclk_i; strobes last one cycle.
//
// Behaviour
// - Shut serial outputs per clock or serial boundary
// - Bit 14 delays serial data by pad latency
// - Bit 13 delays oversample strobe to FIFO timing
// - Bit 12 selects floating or two's complement coefficients
// - Coefficient format resets to two's complement
// - Bit 7 enables noise; bit 3 feeds FIFO
// - Bit 6 steps noise per clock, else symbol
// - Bit 4 bypasses shaping filter and FM generator
// - Bit 2 shifts filters every clock
// - Bit 1 pops FIFO every clock
// - Bit 0 forces sine and cosine to 0x1FFFF
// - Bits 10:7 live in channel 0 only
`timescale 1ns/1ps
`default_nettype none
`include "ctc_consts.svh"

module ctc_channel_test_control
	import ctc_pkg::*;
#(
	parameter logic [1:0] CHANNEL_INDEX = 2'h0,
	parameter int PAD_LATENCY = 1,
	parameter int STROBE_DELAY = 1
)
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Host parallel port
	input wire logic host_cs_n_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [6:0] host_addr_i,
	input wire logic [1:0] host_chan_i,
	input wire logic [15:0] host_wdata_i,
	output logic [15:0] host_rdata_o,
	output logic host_rvalid_o,
	// Serial port timing
	input wire logic serial_run_i,
	input wire logic frame_sync_raw_i,
	input wire logic serial_clock_raw_i,
	input wire logic serial_data_i,
	input wire logic oversample_strobe_i,
	output logic frame_sync_out_o,
	output logic serial_clock_out_o,
	output logic serial_data_int_o,
	output logic oversample_strobe_o,
	// Sample path
	input wire ctc_sample_t sample_i,
	input wire logic symbol_strobe_i,
	input wire logic nco_pop_i,
	input wire logic nco_shift_i,
	output ctc_sample_t fifo_in_o,
	output logic fifo_pop_o,
	output logic filter_shift_o,
	output logic straight_thru_o,
	output logic coef_float_mode_o,
	output logic [2:0] pad_hold_o,
	// Carrier
	input wire ctc_carrier_t carrier_i,
	output ctc_carrier_t carrier_o
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Pick delayed or direct copy of a signal
	function automatic logic dly_pick(input logic en, input logic direct, input logic delayed);
		dly_pick = en ? delayed : direct;
	endfunction

	// Writable bits for this channel
	function automatic logic [15:0] wr_mask(input logic [1:0] chan);
		wr_mask = (chan == 2'h0) ? `CTC_MASK_ALL_CHANNELS : (`CTC_MASK_ALL_CHANNELS & ~`CTC_MASK_CH0_ONLY);
	endfunction

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	logic [15:0] ctrl_reg; // Test control register
	logic [15:0] ctrl_next;
	logic [15:0] rdata_reg; // Read data holding
	logic [15:0] rdata_next;
	logic rvalid_reg; // Read answer pulse
	logic rvalid_next;
	logic hit; // This channel's copy addressed

	// Channel select keeps the four copies apart at one address
	assign hit = !host_cs_n_i && (host_addr_i == `CTC_ADDR_TEST_CTRL) && (host_chan_i == CHANNEL_INDEX);

	// Next register state
	always_comb
	begin
		ctrl_next = ctrl_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		// Masked write drops reserved and, off channel 0, pad/noise bits
		if (hit && host_wr_i)
			ctrl_next = host_wdata_i & wr_mask(CHANNEL_INDEX);
		// Reads of other addresses are left to neighbouring blocks
		if (hit && host_rd_i)
		begin
			rdata_next = ctrl_reg;
			rvalid_next = 1'b1;
		end
	end

	// Register the host side
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			ctrl_reg <= `CTC_RESET_TEST_CTRL;
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign host_rdata_o = rdata_reg;
	assign host_rvalid_o = rvalid_reg;
	assign coef_float_mode_o = ctrl_reg[`CTC_BIT_COEF_FLOAT];
	assign straight_thru_o = ctrl_reg[`CTC_BIT_STRAIGHT_THRU];
	// Pad hold bits only matter electrically; exposed to the pad ring
	assign pad_hold_o = ctrl_reg[`CTC_BIT_PAD_HOLD_HI:`CTC_BIT_PAD_HOLD_LO];

	// ----------------------------------------
	// Serial output shut-off
	// ----------------------------------------
	logic gate_reg; // Serial outputs allowed
	logic gate_next;
	logic sclk_prev_reg; // Last raw serial clock
	logic fs_out_reg;
	logic fs_out_next;
	logic sclk_out_reg;
	logic sclk_out_next;
	logic boundary; // Serial clock just fell

	assign boundary = sclk_prev_reg && !serial_clock_raw_i;

	// Gate follows run at once, or only at a serial clock fall
	always_comb
	begin
		gate_next = gate_reg;
		if (!ctrl_reg[`CTC_BIT_SHUTOFF_ON_SCLK])
			gate_next = serial_run_i;
		else if (boundary)
			gate_next = serial_run_i;
		fs_out_next = frame_sync_raw_i & gate_next;
		sclk_out_next = serial_clock_raw_i & gate_next;
	end

	// Register gate and outputs
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			gate_reg <= 1'b0;
			sclk_prev_reg <= 1'b0;
			fs_out_reg <= 1'b0;
			sclk_out_reg <= 1'b0;
		end
		else
		begin
			gate_reg <= gate_next;
			sclk_prev_reg <= serial_clock_raw_i;
			fs_out_reg <= fs_out_next;
			sclk_out_reg <= sclk_out_next;
		end
	end

	assign frame_sync_out_o = fs_out_reg;
	assign serial_clock_out_o = sclk_out_reg;

	// ----------------------------------------
	// Serial transfer delay alignment
	// ----------------------------------------
	logic [PAD_LATENCY-1:0] sdata_pipe_reg; // Pad latency model
	logic [PAD_LATENCY-1:0] sdata_pipe_next;
	logic [STROBE_DELAY-1:0] strobe_pipe_reg; // Strobe alignment delay
	logic [STROBE_DELAY-1:0] strobe_pipe_next;
	logic sdata_out_reg;
	logic sdata_out_next;
	logic strobe_out_reg;
	logic strobe_out_next;

	// Pipes always run so that switching a delay on finds them full
	always_comb
	begin
		// Oldest bit falls off the top on purpose
		sdata_pipe_next = PAD_LATENCY'({sdata_pipe_reg, serial_data_i});
		strobe_pipe_next = STROBE_DELAY'({strobe_pipe_reg, oversample_strobe_i});
		sdata_out_next = dly_pick(ctrl_reg[`CTC_BIT_SDATA_DELAY], serial_data_i, sdata_pipe_reg[PAD_LATENCY-1]);
		strobe_out_next = dly_pick(ctrl_reg[`CTC_BIT_STROBE_DELAY], oversample_strobe_i,
			strobe_pipe_reg[STROBE_DELAY-1]);
	end

	// Register the pipes
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			sdata_pipe_reg <= '0;
			strobe_pipe_reg <= '0;
			sdata_out_reg <= 1'b0;
			strobe_out_reg <= 1'b0;
		end
		else
		begin
			sdata_pipe_reg <= sdata_pipe_next;
			strobe_pipe_reg <= strobe_pipe_next;
			sdata_out_reg <= sdata_out_next;
			strobe_out_reg <= strobe_out_next;
		end
	end

	assign serial_data_int_o = sdata_out_reg;
	assign oversample_strobe_o = strobe_out_reg;

	// ----------------------------------------
	// Noise source, forced timing and carrier
	// ----------------------------------------
	logic pn_advance; // Step the noise source
	logic [15:0] pn_data; // Current noise word
	ctc_sample_t fifo_in_reg;
	ctc_sample_t fifo_in_next;
	logic pop_reg;
	logic pop_next;
	logic shift_reg;
	logic shift_next;
	ctc_carrier_t carrier_reg;
	ctc_carrier_t carrier_next;

	// Clock rate or symbol rate stepping
	assign pn_advance = ctrl_reg[`CTC_BIT_PN_ENABLE] &&
		(ctrl_reg[`CTC_BIT_PN_FAST] || symbol_strobe_i);

	ctc_pn_source #(
		.WIDTH(16)
	) u_pn (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.advance_i(pn_advance),
		.pn_data_o(pn_data)
	);

	// Source select, forced advances, carrier override
	always_comb
	begin
		if (ctrl_reg[`CTC_BIT_PN_SELECT])
		begin
			fifo_in_next.data = pn_data;
			fifo_in_next.valid = pn_advance;
		end
		else
			fifo_in_next = sample_i;
		pop_next = ctrl_reg[`CTC_BIT_FORCE_POP] || nco_pop_i;
		shift_next = ctrl_reg[`CTC_BIT_FORCE_EDGE] || nco_shift_i;
		if (ctrl_reg[`CTC_BIT_FORCE_CARRIER])
		begin
			carrier_next.sin_val = `CTC_CARRIER_FORCE;
			carrier_next.cos_val = `CTC_CARRIER_FORCE;
		end
		else
			carrier_next = carrier_i;
	end

	// Register the steering outputs
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			fifo_in_reg <= '0;
			pop_reg <= 1'b0;
			shift_reg <= 1'b0;
			carrier_reg <= '0;
		end
		else
		begin
			fifo_in_reg <= fifo_in_next;
			pop_reg <= pop_next;
			shift_reg <= shift_next;
			carrier_reg <= carrier_next;
		end
	end

	assign fifo_in_o = fifo_in_reg;
	assign fifo_pop_o = pop_reg;
	assign filter_shift_o = shift_reg;
	assign carrier_o = carrier_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_SHUTOFF_SYNC: assert property (@(posedge mclk_i) disable iff (srst_i)
		!ctrl_reg[15] && !serial_run_i |=> !frame_sync_out_o && !serial_clock_out_o)
		else $error("serial outputs not stopped at once");
	AST_SHUTOFF_BOUNDARY: assert property (@(posedge mclk_i) disable iff (srst_i)
		ctrl_reg[15] && !boundary |=> $stable(gate_reg))
		else $error("serial gate moved off a serial clock boundary");
	AST_SDATA_DELAY: assert property (@(posedge mclk_i) disable iff (srst_i)
		ctrl_reg[14] |=> serial_data_int_o == $past(serial_data_i, PAD_LATENCY + 1))
		else $error("serial data delay wrong");
	AST_STROBE_DELAY: assert property (@(posedge mclk_i) disable iff (srst_i)
		ctrl_reg[13] |=> oversample_strobe_o == $past(oversample_strobe_i, STROBE_DELAY + 1))
		else $error("oversample strobe delay wrong");
	AST_COEF_RESET: assert property (@(posedge mclk_i) disable iff (srst_i)
		$fell(srst_i) |-> !coef_float_mode_o && ctrl_reg == 16'h0000)
		else $error("coefficient format not two's complement after reset");
	AST_PN_SELECT: assert property (@(posedge mclk_i) disable iff (srst_i)
		ctrl_reg[3] |=> fifo_in_o.data == $past(pn_data))
		else $error("FIFO input not from noise source");
	AST_PN_RATE: assert property (@(posedge mclk_i) disable iff (srst_i)
		(!ctrl_reg[7] || (!ctrl_reg[6] && !symbol_strobe_i)) |=> $stable(pn_data))
		else $error("noise source stepped without its rate");
	AST_FORCE_EDGE: assert property (@(posedge mclk_i) disable iff (srst_i)
		ctrl_reg[2] |=> filter_shift_o)
		else $error("filter shift not forced");
	AST_FORCE_POP: assert property (@(posedge mclk_i) disable iff (srst_i)
		ctrl_reg[1] |=> fifo_pop_o)
		else $error("FIFO pop not forced");
	AST_CARRIER: assert property (@(posedge mclk_i) disable iff (srst_i)
		ctrl_reg[0] |=> carrier_o.sin_val == 18'h1FFFF && carrier_o.cos_val == 18'h1FFFF)
		else $error("carrier not forced");
	AST_CH0_ONLY: assert property (@(posedge mclk_i) disable iff (srst_i)
		CHANNEL_INDEX != 2'h0 |-> ctrl_reg[10:7] == 4'h0)
		else $error("channel-0-only bits set in another channel");
	AST_RESERVED: assert property (@(posedge mclk_i) disable iff (srst_i)
		host_rvalid_o |-> !host_rdata_o[11] && !host_rdata_o[5])
		else $error("reserved bits read nonzero");
	AST_CHANNEL_COPY: assert property (@(posedge mclk_i) disable iff (srst_i)
		host_wr_i && host_chan_i != CHANNEL_INDEX |=> $stable(ctrl_reg))
		else $error("other channel write changed this copy");

endmodule // ctc_channel_test_control
`default_nettype wire

// file: tb/tb_ctc_channel_test_control.sv
// Testbench for the per-channel test control register and its steering.
// Assumes the package and constants header from rtl/ are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ctc_consts.svh"

module tb_ctc_channel_test_control
	import ctc_pkg::*;
;
	// ----------------------------------------
	// Stimulus and observation
	// ----------------------------------------
	localparam int PL = 2; // Pad latency, distinct from strobe delay
	localparam int SD = 3; // Strobe delay
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic cs_n = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [6:0] addr = 7'h17;
	logic [1:0] chan = 2'h0;
	logic [15:0] wdata = 16'h0000;
	logic run = 1'b1, fsr = 1'b1, sclk = 1'b1, sdat = 1'b0, stb = 1'b0;
	logic sym = 1'b0, npop = 1'b0, nshift = 1'b0;
	ctc_sample_t smp = '{data: 16'h1234, valid: 1'b1};
	ctc_carrier_t car = '{sin_val: 18'h00123, cos_val: 18'h00456};
	logic [15:0] rdata, rdata1;
	logic rvalid, rvalid1, fso, sco, sdo, stbo, pop, shift, st, cf;
	logic [2:0] ph;
	ctc_sample_t fin;
	ctc_carrier_t car_o;
	int n_errors = 0;
	int check_count = 0;

	// Clock at 4 ns period
	always #2 mclk_i = ~mclk_i;

	// ----------------------------------------
	// Channel 0 and channel 1 copies
	// ----------------------------------------
	ctc_channel_test_control #(.CHANNEL_INDEX(2'h0), .PAD_LATENCY(PL), .STROBE_DELAY(SD))
	ctc_channel_test_control_inst (.mclk_i(mclk_i), .srst_i(srst_i), .host_cs_n_i(cs_n), .host_wr_i(wr),
		.host_rd_i(rd), .host_addr_i(addr), .host_chan_i(chan), .host_wdata_i(wdata), .host_rdata_o(rdata),
		.host_rvalid_o(rvalid), .serial_run_i(run), .frame_sync_raw_i(fsr), .serial_clock_raw_i(sclk),
		.serial_data_i(sdat), .oversample_strobe_i(stb), .frame_sync_out_o(fso), .serial_clock_out_o(sco),
		.serial_data_int_o(sdo), .oversample_strobe_o(stbo), .sample_i(smp), .symbol_strobe_i(sym),
		.nco_pop_i(npop), .nco_shift_i(nshift), .fifo_in_o(fin), .fifo_pop_o(pop), .filter_shift_o(shift),
		.straight_thru_o(st), .coef_float_mode_o(cf), .pad_hold_o(ph), .carrier_i(car), .carrier_o(car_o));

	// Second copy shares the bus; only its register port is watched
	ctc_channel_test_control #(.CHANNEL_INDEX(2'h1), .PAD_LATENCY(PL), .STROBE_DELAY(SD))
	ctc_channel_test_control_inst_ch1 (.mclk_i(mclk_i), .srst_i(srst_i), .host_cs_n_i(cs_n), .host_wr_i(wr),
		.host_rd_i(rd), .host_addr_i(addr), .host_chan_i(chan), .host_wdata_i(wdata), .host_rdata_o(rdata1),
		.host_rvalid_o(rvalid1), .serial_run_i(run), .frame_sync_raw_i(fsr), .serial_clock_raw_i(sclk),
		.serial_data_i(sdat), .oversample_strobe_i(stb), .frame_sync_out_o(), .serial_clock_out_o(),
		.serial_data_int_o(), .oversample_strobe_o(), .sample_i(smp), .symbol_strobe_i(sym),
		.nco_pop_i(npop), .nco_shift_i(nshift), .fifo_in_o(), .fifo_pop_o(), .filter_shift_o(),
		.straight_thru_o(), .coef_float_mode_o(), .pad_hold_o(), .carrier_i(car), .carrier_o());

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Wait n edges, then look just after the last one
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	// One-cycle write strobe; ctrl holds it after the second edge
	task automatic wr_reg(input logic [1:0] ch, input logic [6:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		cs_n <= 1'b0;
		wr <= 1'b1;
		chan <= ch;
		addr <= a;
		wdata <= d;
		@(posedge mclk_i);
		cs_n <= 1'b1;
		wr <= 1'b0;
	endtask

	// Read answer pulses one cycle after the strobe edge
	task automatic rd_reg(input logic [1:0] ch, input logic [15:0] exp);
		@(posedge mclk_i);
		cs_n <= 1'b0;
		rd <= 1'b1;
		chan <= ch;
		addr <= 7'h17;
		@(posedge mclk_i);
		cs_n <= 1'b1;
		rd <= 1'b0;
		#1;
		chk("rvalid", 36'h1, (ch == 2'h0) ? rvalid : rvalid1);
		chk("rdata", {20'h0, exp}, {20'h0, (ch == 2'h0) ? rdata : rdata1});
	endtask

	// Cycles from a one-cycle pulse to its appearance, bounded
	task automatic latency(output int nd, output int ns);
		nd = 0;
		ns = 0;
		@(posedge mclk_i);
		sdat <= 1'b1;
		stb <= 1'b1;
		@(posedge mclk_i);
		sdat <= 1'b0;
		stb <= 1'b0;
		#1;
		for (int i = 1; i <= 8; i++)
		begin
			if (sdo === 1'b1 && nd == 0) nd = i;
			if (stbo === 1'b1 && ns == 0) ns = i;
			tick(1);
		end
		if (nd == 0 || ns == 0)
		begin
			n_errors++;
			end_sim();
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Masks per channel, reserved bits, copy per channel
	task automatic t_regs();
		rd_reg(2'h0, 16'h0000);
		chk("coef_float", 36'h0, cf);
		wr_reg(2'h0, 7'h17, 16'hFFFF);
		rd_reg(2'h0, 16'hF7DF);
		chk("coef_float", 36'h1, cf);
		chk("straight_thru", 36'h1, st);
		chk("pad_hold", 36'h7, ph);
		wr_reg(2'h1, 7'h17, 16'hFFFF);
		rd_reg(2'h1, 16'hF05F);
		wr_reg(2'h0, 7'h16, 16'h0000);
		rd_reg(2'h0, 16'hF7DF);
		wr_reg(2'h0, 7'h17, 16'h0000);
		rd_reg(2'h0, 16'h0000);
		rd_reg(2'h1, 16'hF05F);
		chk("coef_float", 36'h0, cf);
	endtask

	// Forced pop, shift and carrier against NCO pass-through
	task automatic t_force();
		wr_reg(2'h0, 7'h17, 16'h0007);
		tick(2);
		chk("fifo_pop", 36'h1, pop);
		chk("filter_shift", 36'h1, shift);
		chk("carrier", {18'h1FFFF, 18'h1FFFF}, car_o);
		wr_reg(2'h0, 7'h17, 16'h0000);
		@(posedge mclk_i);
		npop <= 1'b1;
		tick(2);
		chk("fifo_pop", 36'h1, pop);
		chk("filter_shift", 36'h0, shift);
		chk("carrier", car, car_o);
		@(posedge mclk_i);
		npop <= 1'b0;
		tick(2);
		chk("fifo_pop", 36'h0, pop);
	endtask

	// Noise at clock rate, then symbol rate, then normal input
	task automatic t_pn();
		logic [15:0] d0;
		wr_reg(2'h0, 7'h17, 16'h00C8);
		tick(2);
		d0 = fin.data;
		chk("pn_valid", 36'h1, fin.valid);
		tick(1);
		chk("pn_step", 36'h1, d0 !== fin.data);
		wr_reg(2'h0, 7'h17, 16'h0088);
		tick(2);
		d0 = fin.data;
		chk("pn_valid", 36'h0, fin.valid);
		tick(1);
		chk("pn_hold", {20'h0, d0}, {20'h0, fin.data});
		@(posedge mclk_i);
		sym <= 1'b1;
		@(posedge mclk_i);
		sym <= 1'b0;
		#1;
		chk("pn_valid", 36'h1, fin.valid);
		wr_reg(2'h0, 7'h17, 16'h0000);
		tick(2);
		chk("fifo_in", {19'h0, smp}, {19'h0, fin});
	endtask

	// Serial data and strobe delays off and on
	task automatic t_delay();
		int nd;
		int ns;
		latency(nd, ns);
		chk("sdata_lat", 36'h1, nd);
		chk("strobe_lat", 36'h1, ns);
		wr_reg(2'h0, 7'h17, 16'h6000);
		latency(nd, ns);
		chk("sdata_lat", 1 + PL, nd);
		chk("strobe_lat", 1 + SD, ns);
	endtask

	// Shut-off at once, then only at a serial clock fall
	task automatic t_shut();
		wr_reg(2'h0, 7'h17, 16'h0000);
		tick(3);
		chk("frame_sync", 36'h1, fso);
		chk("serial_clock", 36'h1, sco);
		@(posedge mclk_i);
		run <= 1'b0;
		tick(3);
		chk("frame_sync", 36'h0, fso);
		chk("serial_clock", 36'h0, sco);
		// Reopen the gate while shut-off is still immediate
		@(posedge mclk_i);
		run <= 1'b1;
		tick(3);
		chk("frame_sync", 36'h1, fso);
		wr_reg(2'h0, 7'h17, 16'h8000);
		tick(4);
		chk("frame_sync", 36'h1, fso);
		@(posedge mclk_i);
		run <= 1'b0;
		tick(5);
		chk("frame_sync", 36'h1, fso);
		@(posedge mclk_i);
		sclk <= 1'b0;
		tick(4);
		chk("frame_sync", 36'h0, fso);
	endtask

	// ----------------------------------------
	// Verdict and main sequence
	// ----------------------------------------
	task automatic end_sim();
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang guard well above the expected run length
	initial
	begin
		#100000;
		n_errors++;
		end_sim();
	end

	initial
	begin
		repeat (3) @(posedge mclk_i);
		srst_i <= 1'b0;
		t_regs();
		t_force();
		t_pn();
		t_delay();
		t_shut();
		end_sim();
	end
endmodule // tb_ctc_channel_test_control
`default_nettype wire
